// >>> verilog/vsbu_bridge.sv
/*
 Board-side UART bridge: target pins on one side, host byte streams on the other.
 Assumes the host selects USB or socket traffic and applies config from reset.
*/
`timescale 1ns/100ps
`default_nettype none
module vsbu_bridge (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [31:0] baud_rate,
    input wire logic baud_load,
    input wire logic [1:0] hs_mode,
    input wire logic vcom_enable,
    input wire logic sock_connected,
    input wire logic usb_tx_valid,
    output logic usb_tx_ready,
    input wire logic [7:0] usb_tx_data,
    input wire logic sock_tx_valid,
    output logic sock_tx_ready,
    input wire logic [7:0] sock_tx_data,
    output logic usb_rx_valid,
    input wire logic usb_rx_ready,
    output logic sock_rx_valid,
    input wire logic sock_rx_ready,
    output logic [7:0] rx_data,
    output logic target_rx,
    input wire logic target_tx,
    output logic target_cts_o,
    output logic target_cts_oe_n,
    input wire logic target_rts,
    output logic [15:0] divisor
);
    import vsbu_pkg::*;

    // Baud config
    logic [DIV_W-1:0] div_reg;
    logic [1:0] mode_reg;
    wire [31:0] div_raw = CLK_HZ / ((baud_rate == 32'h0) ? 32'h1 : baud_rate);
    wire [DIV_W-1:0] div_next = (div_raw > 32'(DIV_MAX)) ? DIV_MAX :
                                (div_raw < 32'(DIV_MIN)) ? DIV_MIN : div_raw[DIV_W-1:0];
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            div_reg <= DIV_DEFAULT;
            mode_reg <= VSBU_HS_DISABLE;
        end
        else
        begin
            if (baud_load)
            begin
                div_reg <= div_next;
            end
            mode_reg <= hs_mode;
        end
    end
    assign divisor = div_reg;

    wire drive_cts = mode_reg[0];
    wire check_rts = mode_reg[1];

    // Pin synchronisers
    logic rxd_s1_reg, rxd_s2_reg, rts_s1_reg, rts_s2_reg;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rxd_s1_reg <= LINE_IDLE;
            rxd_s2_reg <= LINE_IDLE;
            rts_s1_reg <= 1'b0;
            rts_s2_reg <= 1'b0;
        end
        else
        begin
            rxd_s1_reg <= target_tx;
            rxd_s2_reg <= rxd_s1_reg;
            rts_s1_reg <= target_rts;
            rts_s2_reg <= rts_s1_reg;
        end
    end
    wire tx_allowed = !check_rts || rts_s2_reg;

    // Host to target path, channel select
    wire [7:0] host_data = sock_connected ? sock_tx_data : usb_tx_data;
    wire host_valid = sock_connected ? sock_tx_valid : usb_tx_valid;
    logic tf_in_ready, tf_out_valid, tf_pop;
    logic [7:0] tf_out_data;
    wire tf_push = host_valid && vcom_enable;
    assign usb_tx_ready = !sock_connected && vcom_enable && tf_in_ready;
    assign sock_tx_ready = sock_connected && vcom_enable && tf_in_ready;
    vsbu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(tf_push),
        .in_ready(tf_in_ready),
        .in_data(host_data),
        .out_valid(tf_out_valid),
        .out_ready(tf_pop),
        .out_data(tf_out_data)
    );

    // Transmitter
    vsbu_st_e tx_st_reg;
    logic [DIV_W-1:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [9:0] tx_sh_reg;
    wire tx_tick = (tx_cnt_reg == div_reg - DIV_W'(1));
    wire tx_start = (tx_st_reg == VSBU_ST_IDLE) && tf_out_valid && tx_allowed && vcom_enable;
    assign tf_pop = tx_start;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tx_st_reg <= VSBU_ST_IDLE;
            tx_cnt_reg <= '0;
            tx_bit_reg <= 4'h0;
            tx_sh_reg <= 10'h3FF;
        end
        else
        begin
            case (tx_st_reg)
                VSBU_ST_IDLE:
                begin
                    tx_cnt_reg <= '0;
                    if (tx_start)
                    begin
                        tx_sh_reg <= {STOP_LVL, tf_out_data, START_LVL};
                        tx_bit_reg <= 4'h0;
                        tx_st_reg <= VSBU_ST_SHIFT;
                    end
                end
                VSBU_ST_SHIFT:
                begin
                    // Request drop ignored here so the frame completes
                    if (tx_tick)
                    begin
                        tx_cnt_reg <= '0;
                        tx_sh_reg <= {LINE_IDLE, tx_sh_reg[9:1]};
                        if (tx_bit_reg == LAST_BIT)
                        begin
                            tx_st_reg <= VSBU_ST_IDLE;
                        end
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                    end
                    else
                    begin
                        tx_cnt_reg <= tx_cnt_reg + DIV_W'(1);
                    end
                end
                default:
                begin
                    tx_st_reg <= VSBU_ST_IDLE;
                end
            endcase
        end
    end
    assign target_rx = tx_sh_reg[0];

    // Receiver, samples mid-bit
    vsbu_st_e rx_st_reg;
    logic [DIV_W-1:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_push_reg;
    logic [7:0] rx_byte_reg;
    wire rx_half = (rx_cnt_reg == {1'b0, div_reg[DIV_W-1:1]});
    wire rx_tick = (rx_cnt_reg == div_reg - DIV_W'(1));
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rx_st_reg <= VSBU_ST_IDLE;
            rx_cnt_reg <= '0;
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 8'h00;
            rx_push_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
        end
        else
        begin
            rx_push_reg <= 1'b0;
            case (rx_st_reg)
                VSBU_ST_IDLE:
                begin
                    rx_cnt_reg <= '0;
                    if (rxd_s2_reg == START_LVL)
                    begin
                        rx_st_reg <= VSBU_ST_WAIT;
                    end
                end
                VSBU_ST_WAIT:
                begin
                    // Glitch shorter than half a bit is dropped
                    if (rx_half)
                    begin
                        rx_cnt_reg <= '0;
                        rx_bit_reg <= 4'h0;
                        rx_st_reg <= (rxd_s2_reg == START_LVL) ? VSBU_ST_SHIFT : VSBU_ST_IDLE;
                    end
                    else
                    begin
                        rx_cnt_reg <= rx_cnt_reg + DIV_W'(1);
                    end
                end
                VSBU_ST_SHIFT:
                begin
                    if (rx_tick)
                    begin
                        rx_cnt_reg <= '0;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == 4'(DATA_BITS))
                        begin
                            rx_st_reg <= VSBU_ST_IDLE;
                            // Framing error bytes are discarded
                            rx_push_reg <= (rxd_s2_reg == STOP_LVL) && vcom_enable;
                            rx_byte_reg <= rx_sh_reg;
                        end
                        else
                        begin
                            rx_sh_reg <= {rxd_s2_reg, rx_sh_reg[7:1]};
                        end
                    end
                    else
                    begin
                        rx_cnt_reg <= rx_cnt_reg + DIV_W'(1);
                    end
                end
                default:
                begin
                    rx_st_reg <= VSBU_ST_IDLE;
                end
            endcase
        end
    end

    // Target to host path
    logic rf_in_ready, rf_out_valid;
    wire rf_pop = sock_connected ? sock_rx_ready : usb_rx_ready;
    vsbu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(rx_push_reg),
        .in_ready(rf_in_ready),
        .in_data(rx_byte_reg),
        .out_valid(rf_out_valid),
        .out_ready(rf_pop && vcom_enable),
        .out_data(rx_data)
    );
    assign usb_rx_valid = rf_out_valid && vcom_enable && !sock_connected;
    assign sock_rx_valid = rf_out_valid && vcom_enable && sock_connected;

    // Clear-to-send; no spare slot is kept at full, so the target must heed it
    assign target_cts_o = rf_in_ready;
    assign target_cts_oe_n = !drive_cts;

    chk_cts_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (drive_cts && !rf_in_ready) |-> (!target_cts_o && !target_cts_oe_n))
        else $error("cts not low on full");
    chk_cts_undriven: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !mode_reg[0] |-> target_cts_oe_n)
        else $error("cts driven in wrong mode");
    chk_rts_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (check_rts && !rts_s2_reg) |-> !tf_pop)
        else $error("start while rts low");
    chk_frame_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tx_st_reg == VSBU_ST_SHIFT && !tx_tick) |=> tx_st_reg == VSBU_ST_SHIFT)
        else $error("frame aborted");
    chk_start_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_start |=> !target_rx)
        else $error("no start bit");
    chk_idle_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_st_reg == VSBU_ST_IDLE |-> target_rx)
        else $error("line not idle high");
    chk_enable_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !vcom_enable |-> !(usb_rx_valid || sock_rx_valid || usb_tx_ready || sock_tx_ready))
        else $error("data passed while disabled");
    chk_sock_prio: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sock_connected |-> !(usb_rx_valid || usb_tx_ready))
        else $error("usb active with socket");
    // Checked one edge after reset so the first edge never sees unknowns
    chk_reset_div: assert property (@(posedge ref_clk)
        sys_rst |=> (div_reg == DIV_DEFAULT && mode_reg == VSBU_HS_DISABLE))
        else $error("reset defaults wrong");
    chk_bit_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tx_st_reg == VSBU_ST_SHIFT && !tx_tick) |=> $stable(target_rx))
        else $error("line moved inside a bit");
    chk_stop_bit: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tx_st_reg == VSBU_ST_SHIFT && tx_bit_reg == LAST_BIT) |-> target_rx)
        else $error("stop bit not high");
    chk_div_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (div_reg >= DIV_MIN && div_reg <= DIV_MAX))
        else $error("divisor out of range");
    chk_baud_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
        baud_load |=> (div_reg == $past(div_next)))
        else $error("divisor not loaded");
    chk_rts_ignored: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !check_rts |-> tx_allowed)
        else $error("request not ignored");
    chk_pop_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tf_pop |-> (tf_out_valid && vcom_enable))
        else $error("pop while disabled or empty");
    chk_rx_stop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_push_reg |-> ($past(rxd_s2_reg) == STOP_LVL))
        else $error("byte stored without stop bit");
    chk_rx_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_push_reg |-> $past(vcom_enable))
        else $error("byte stored while disabled");
    chk_cts_driven: assert property (@(posedge ref_clk) disable iff (sys_rst)
        drive_cts |-> !target_cts_oe_n)
        else $error("cts not driven");
    chk_sock_rx_sel: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sock_rx_valid |-> sock_connected)
        else $error("socket valid without socket");
    chk_busy_no_pop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (tx_st_reg != VSBU_ST_IDLE) |-> !tf_pop)
        else $error("pop during a frame");
    chk_mode_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'b1 |=> (mode_reg == $past(hs_mode)))
        else $error("mode not taken");
    cov_tx_byte: cover property (@(posedge ref_clk) tx_start);
    cov_rx_byte: cover property (@(posedge ref_clk) rx_push_reg);
    cov_rx_full: cover property (@(posedge ref_clk) !rf_in_ready && drive_cts);
    cov_rts_hold: cover property (@(posedge ref_clk) check_rts && !rts_s2_reg && tf_out_valid);
    cov_sock_tx: cover property (@(posedge ref_clk) sock_tx_valid && sock_tx_ready);
endmodule : vsbu_bridge
`default_nettype wire

// >>> verilog/vsbu_pkg.sv
/*
 Package for the virtual serial bridge UART: framing, baud and handshake constants.
 Assumes a 50 MHz ref_clk shared by every file that imports it.
*/
package vsbu_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned BAUD_DEFAULT = 115200;
    localparam int unsigned BAUD_MIN = 9600;
    localparam int unsigned BAUD_MAX = 921600;
    localparam int DIV_W = 16;
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
    localparam int DATA_BITS = 8;
    localparam logic [3:0] LAST_BIT = 4'h9;
    localparam int FIFO_DEPTH = 32;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LVL = 1'b0;
    localparam logic STOP_LVL = 1'b1;
    typedef enum logic [1:0] {
        VSBU_HS_DISABLE = 2'b00,
        VSBU_HS_RTS = 2'b01,
        VSBU_HS_CTS = 2'b10,
        VSBU_HS_RTSCTS = 2'b11
    } vsbu_hs_e;
    typedef enum logic [1:0] {
        VSBU_ST_IDLE = 2'b00,
        VSBU_ST_SHIFT = 2'b01,
        VSBU_ST_WAIT = 2'b10
    } vsbu_st_e;
endpackage : vsbu_pkg

// >>> verilog/vsbu_fifo.sv
/*
 Synchronous FIFO with width and depth parameters, valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module vsbu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_reg;
    logic [AW:0] rp_reg;
    wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    wire empty = (wp_reg == rp_reg);
    wire do_wr = in_valid && !full;
    wire do_rd = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rp_reg[AW-1:0]];
    always_ff @(posedge ref_clk)
    begin
        if (do_wr)
        begin
            mem[wp_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_reg + (AW+1)'(do_wr);
            rp_reg <= rp_reg + (AW+1)'(do_rd);
        end
    end
endmodule : vsbu_fifo
`default_nettype wire

// >>> testbench/vsbu_target_model.sv
/*
 Target microcontroller UART model with request/clear-to-send pins.
 Assumes the bench gives the bit time in clocks and reads the received bytes.
*/
`timescale 1ns/100ps
`default_nettype none
module vsbu_target_model (
    input wire logic ref_clk,
    input wire logic [15:0] bit_clks,
    input wire logic line_in,
    output logic line_out,
    input wire logic cts_in,
    output logic rts_out,
    output logic got_stb,
    output logic [7:0] got_byte
);
    logic rts_lvl = 1'b1;
    logic obey_cts = 1'b0;
    int frame_err = 0;
    int got_cnt = 0;
    assign rts_out = rts_lvl;
    initial line_out = 1'b1; // Idle high between frames
    initial got_stb = 1'b0;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0}; // 8N1, start low, LSB first
        while (obey_cts && cts_in !== 1'b1) @(posedge ref_clk); // Held off by clear-to-send
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk);
            #1 line_out = fr[i];
            repeat (bit_clks - 1) @(posedge ref_clk);
        end
    endtask : send_byte
    // Always takes a whole character, even after dropping request
    always
    begin
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge ref_clk);
        if (line_in !== 1'b0) frame_err++;
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_clks) @(posedge ref_clk);
            got_byte[i] = line_in; // LSB first
        end
        repeat (bit_clks) @(posedge ref_clk);
        if (line_in !== 1'b1) frame_err++; // Stop bit high
        got_cnt++;
        #1 got_stb = 1'b1;
        @(posedge ref_clk);
        #1 got_stb = 1'b0;
    end
endmodule : vsbu_target_model
`default_nettype wire

// >>> testbench/tb.sv
/*
 Self-checking bench for vsbu_bridge against the target UART model.
 Assumes a 50 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vsbu_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, baud_load = 0, vcom_enable = 1, sock_connected = 0;
    logic usb_tx_valid = 0, sock_tx_valid = 0, usb_rx_ready = 1, sock_rx_ready = 1, ok;
    logic [31:0] baud_rate = 0;
    logic [1:0] hs_mode = 0;
    logic [7:0] usb_tx_data = 0, sock_tx_data = 0, rx_data, got_byte;
    logic usb_tx_ready, sock_tx_ready, usb_rx_valid, sock_rx_valid, target_rx, target_tx;
    logic target_cts_o, target_cts_oe_n, target_rts, got_stb, cts_wire;
    logic [15:0] divisor, bit_clks = 16'h0036;
    logic [7:0] exp_tgt[$];
    logic [8:0] exp_host[$];
    int n_mismatch = 0, checks_done = 0, n, c0;
    // Pull-up on the clear-to-send wire while it is not driven
    assign cts_wire = target_cts_oe_n ? 1'b1 : target_cts_o;
    vsbu_bridge uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .baud_rate(baud_rate),
        .baud_load(baud_load), .hs_mode(hs_mode), .vcom_enable(vcom_enable),
        .sock_connected(sock_connected), .usb_tx_valid(usb_tx_valid),
        .usb_tx_ready(usb_tx_ready), .usb_tx_data(usb_tx_data), .sock_tx_valid(sock_tx_valid),
        .sock_tx_ready(sock_tx_ready), .sock_tx_data(sock_tx_data), .usb_rx_valid(usb_rx_valid),
        .usb_rx_ready(usb_rx_ready), .sock_rx_valid(sock_rx_valid),
        .sock_rx_ready(sock_rx_ready), .rx_data(rx_data), .target_rx(target_rx),
        .target_tx(target_tx), .target_cts_o(target_cts_o), .target_cts_oe_n(target_cts_oe_n),
        .target_rts(target_rts), .divisor(divisor));
    vsbu_target_model tgt (.ref_clk(ref_clk), .bit_clks(bit_clks), .line_in(target_rx),
        .line_out(target_tx), .cts_in(cts_wire), .rts_out(target_rts), .got_stb(got_stb),
        .got_byte(got_byte));
    initial forever #10 ref_clk = ~ref_clk;
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic host_tx(input logic sock, input logic [7:0] b, input int lim);
        ok = 1'b0;
        @(posedge ref_clk);
        #1 usb_tx_valid = !sock;
        sock_tx_valid = sock;
        usb_tx_data = b;
        sock_tx_data = b;
        for (int i = 0; i < lim && !ok; i++)
        begin
            @(negedge ref_clk);
            ok = sock ? sock_tx_ready : usb_tx_ready;
            @(posedge ref_clk);
            #1;
        end
        usb_tx_valid = 0;
        sock_tx_valid = 0;
        if (ok === 1'b1) exp_tgt.push_back(b);
    endtask : host_tx
    task automatic tgt_tx(input logic sock, input logic [7:0] b);
        exp_host.push_back({sock, b});
        tgt.send_byte(b);
    endtask : tgt_tx
    task automatic drain(input string nm);
        for (int i = 0; i < 40000 && (exp_tgt.size() + exp_host.size()) > 0; i++)
            @(posedge ref_clk);
        #1;
        check("queues empty", 0, 16'(exp_tgt.size() + exp_host.size()));
        $display("test %s done", nm);
    endtask : drain
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    always @(posedge ref_clk)
    begin
        if (got_stb) check("byte at target", exp_tgt.size() ? 16'(exp_tgt.pop_front()) : 16'hXXXX, 16'(got_byte));
        if ((usb_rx_valid && usb_rx_ready) || (sock_rx_valid && sock_rx_ready)) check("byte at host", exp_host.size() ? 16'(exp_host.pop_front()) : 16'hXXXX, {7'h00, sock_rx_valid, rx_data});
        if (sock_connected && usb_rx_valid) check("usb valid under socket", 0, 1);
    end
    initial
    begin
        #1_800_000;
        n_mismatch++;
        close_out();
    end
    initial
    begin
        logic [31:0] rates[4] = '{32'd9600, 32'd4800, 32'd2000000, 32'd921600};
        logic [15:0] divs[4] = '{DIV_MAX, DIV_MAX, DIV_MIN, DIV_MIN};
        void'($urandom(44815));
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 0;
        @(negedge ref_clk);
        check("divisor", DIV_DEFAULT, divisor);
        check("idle line", 1, target_rx);
        check("cts enable", 1, target_cts_oe_n);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            #1 baud_rate = rates[i];
            baud_load = 1;
            @(posedge ref_clk);
            #1 baud_load = 0;
            repeat (2) @(negedge ref_clk);
            check("divisor", divs[i], divisor);
        end
        $display("test baud done");
        bit_clks = DIV_MIN;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge ref_clk);
            #1 hs_mode = 2'(m);
            repeat (3) @(negedge ref_clk);
            check("cts enable", 16'(!m[0]), target_cts_oe_n);
        end
        $display("test mode done");
        hs_mode = VSBU_HS_DISABLE;
        tgt.rts_lvl = 0;
        for (int i = 0; i < 4; i++) host_tx(0, 8'($urandom), 20);
        for (int i = 0; i < 3; i++) tgt_tx(0, 8'($urandom));
        drain("usb");
        vcom_enable = 0;
        host_tx(0, 8'hA5, 6);
        check("accept while disabled", 0, 16'(ok));
        vcom_enable = 1;
        sock_connected = 1;
        host_tx(0, 8'h5A, 6);
        check("usb accept under socket", 0, 16'(ok));
        host_tx(1, 8'($urandom), 20);
        tgt_tx(1, 8'($urandom));
        drain("socket");
        sock_connected = 0;
        hs_mode = VSBU_HS_RTSCTS;
        tgt.rts_lvl = 1;
        tgt.obey_cts = 1;
        usb_rx_ready = 0;
        for (int i = 0; i < FIFO_DEPTH; i++) tgt_tx(0, 8'($urandom));
        repeat (3) @(negedge ref_clk);
        check("cts when full", 0, target_cts_o);
        check("cts enable", 0, target_cts_oe_n);
        fork
            tgt_tx(0, 8'($urandom));
        join_none
        repeat (bit_clks * 12) @(posedge ref_clk);
        #1 usb_rx_ready = 1;
        drain("receive fill");
        check("cts after drain", 1, target_cts_o);
        hs_mode = VSBU_HS_CTS;
        tgt.rts_lvl = 0;
        n = 0;
        do
        begin
            host_tx(0, 8'($urandom), 4);
            n += int'(ok === 1'b1);
        end
        while (ok === 1'b1 && n < 40);
        check("send fifo refuses", 1, 16'(n >= FIFO_DEPTH && n < 36));
        check("line idle while held", 1, target_rx);
        c0 = tgt.got_cnt;
        tgt.rts_lvl = 1;
        for (int i = 0; i < 200 && target_rx; i++) @(posedge ref_clk);
        repeat (bit_clks * 4) @(posedge ref_clk);
        #1 tgt.rts_lvl = 0;
        repeat (bit_clks * 22) @(posedge ref_clk);
        #1;
        check("chars after drop", 1, 16'(tgt.got_cnt - c0));
        check("line idle after drop", 1, target_rx);
        tgt.rts_lvl = 1;
        drain("request gating");
        check("framing errors", 0, 16'(tgt.frame_err));
        close_out();
    end
endmodule : tb
`default_nettype wire
